// ===== inc/pbw_pkg.sv
package pbw_pkg;
   // power states
   typedef enum logic [2:0] {
      PBW_S0,
      PBW_S1,
      PBW_S3,
      PBW_S4,
      PBW_S5
   } pbw_state_e;

   // state codes on the status output
   localparam logic [2:0] STATE_S0 = 3'h0;
   localparam logic [2:0] STATE_S1 = 3'h1;
   localparam logic [2:0] STATE_S3 = 3'h3;
   localparam logic [2:0] STATE_S4 = 3'h4;
   localparam logic [2:0] STATE_S5 = 3'h5;

   // clock and timing
   localparam int CLK_MHZ = 250;
   localparam int LONG_PRESS_MS = 4000;
   localparam longint LONG_PRESS_CYC_L = longint'(LONG_PRESS_MS) * 1000 * CLK_MHZ;
   localparam logic [31:0] LONG_PRESS_CYC = LONG_PRESS_CYC_L[31:0];
   localparam int DEBOUNCE_US = 10;
   localparam int DEBOUNCE_CYC_I = DEBOUNCE_US * CLK_MHZ;
   localparam logic [15:0] DEBOUNCE_CYC = DEBOUNCE_CYC_I[15:0];

   // wake source bit positions
   localparam int WK_PWR = 0;
   localparam int WK_RTC = 1;
   localparam int WK_LAN = 2;
   localparam int WK_PME = 3;
   localparam int WK_RSR = 4;
   localparam int WK_RSR_USB = 5;
   localparam int WK_RING = 6;
   localparam int WK_USB = 7;
   localparam int WK_PS2 = 8;
   localparam int WK_N = 9;

   // masks of sources accepted per state
   localparam logic [8:0] WAKE_MASK_S1S3 = 9'h1FF;
   localparam logic [8:0] WAKE_MASK_S4S5 = 9'h01F;
   localparam logic [8:0] WAKE_LAN_PME = 9'h00C;
endpackage : pbw_pkg

// ===== design/pbw_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser plus steady-level debouncer
module pbw_sync (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic async_in,
   input wire logic [15:0] settle_cyc,
   output logic clean_out
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic prev_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic clean_reg;
   logic clean_next;

   always_comb begin
      prev_next = sync_reg;
      cnt_next = cnt_reg;
      clean_next = clean_reg;
      if (sync_reg != prev_reg) begin
         cnt_next = 16'h0000;
      end else if (cnt_reg < settle_cyc) begin
         cnt_next = cnt_reg + 16'h0001;
      end else begin
         clean_next = sync_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         cnt_reg <= 16'h0000;
         clean_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= prev_next;
         cnt_reg <= cnt_next;
         clean_reg <= clean_next;
      end
   end

   assign clean_out = clean_reg;
endmodule : pbw_sync

// ===== design/pbw_ctrl.sv
`timescale 1ns/100ps
// Operation
// - in soft-off a press shorter than four seconds powers the system on to working.
// - in working a press shorter than four seconds sends the system to sleep.
// - in working a hold of four seconds or more forces a fail-safe power-off to soft-off.
// - in sleep a press shorter than four seconds wakes the system to working.
// - in sleep a hold of four seconds or more powers the system off to soft-off.
// - power switch, rtc alarm, lan and power-management event wake from S1, S3, S4 and S5.
// - modem ring, usb and ps/2 activity wake only from S1 or S3 and are ignored in S4 and S5.
// - lan and power-management-event wake from S5 are off after reset until enabled.
// - riser wake is taken from S1 to S5, except its usb wake which is ignored in S4 and S5.
// - S1 holds the processor in stop-grant with context kept and resumes without restart.
// - S3 to S5 cut power except wake logic, and leaving S5 demands a cold boot.
module pbw_ctrl #(
   parameter logic [31:0] LONG_PRESS = pbw_pkg::LONG_PRESS_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic pwr_sw_n,
   input wire logic rtc_alarm,
   input wire logic lan_wake,
   input wire logic power_mgmt_event_n,
   input wire logic riser_wake,
   input wire logic riser_usb_wake,
   input wire logic ring_a,
   input wire logic usb_wake,
   input wire logic ps2_wake,
   input wire logic s5_lan_pme_en,
   input wire logic os_sleep_req,
   input wire logic [2:0] os_sleep_state,
   output logic [2:0] pwr_state,
   output logic stop_grant,
   output logic main_pwr_on,
   output logic cold_boot,
   output logic sleep_req_ack
);
   logic sw_clean;
   logic [8:0] wk_meta_reg;
   logic [8:0] wk_sync_reg;
   logic [8:0] wk_raw;
   logic en_meta_reg;
   logic en_sync_reg;
   logic os_req_prev_reg;

   pbw_pkg::pbw_state_e st_reg;
   pbw_pkg::pbw_state_e st_next;
   logic [31:0] press_reg;
   logic [31:0] press_next;
   logic long_done_reg;
   logic long_done_next;
   logic cold_reg;
   logic cold_next;
   logic ack_reg;
   logic ack_next;
   logic sw_prev_reg;
   logic [8:0] wake_mask;
   logic wake_hit;
   logic short_rel;
   logic long_hit;
   logic os_req_rise;

   pbw_sync u_sw (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_in(~pwr_sw_n),
      .settle_cyc(pbw_pkg::DEBOUNCE_CYC),
      .clean_out(sw_clean)
   );

   // wake sources by bit position, the switch itself wakes through short_rel
   assign wk_raw[pbw_pkg::WK_PWR] = 1'b0;
   assign wk_raw[pbw_pkg::WK_RTC] = rtc_alarm;
   assign wk_raw[pbw_pkg::WK_LAN] = lan_wake;
   assign wk_raw[pbw_pkg::WK_PME] = ~power_mgmt_event_n;
   assign wk_raw[pbw_pkg::WK_RSR] = riser_wake;
   assign wk_raw[pbw_pkg::WK_RSR_USB] = riser_usb_wake;
   assign wk_raw[pbw_pkg::WK_RING] = ring_a;
   assign wk_raw[pbw_pkg::WK_USB] = usb_wake;
   assign wk_raw[pbw_pkg::WK_PS2] = ps2_wake;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wk_meta_reg <= 9'h000;
         wk_sync_reg <= 9'h000;
         en_meta_reg <= 1'b0;
         en_sync_reg <= 1'b0;
         os_req_prev_reg <= 1'b0;
         sw_prev_reg <= 1'b0;
      end else begin
         wk_meta_reg <= wk_raw;
         wk_sync_reg <= wk_meta_reg;
         en_meta_reg <= s5_lan_pme_en;
         en_sync_reg <= en_meta_reg;
         os_req_prev_reg <= os_sleep_req;
         sw_prev_reg <= sw_clean;
      end
   end

   // press measurement on the debounced switch
   assign short_rel = sw_prev_reg && !sw_clean && !long_done_reg;
   assign long_hit = sw_clean && !long_done_reg && (press_reg >= LONG_PRESS - 32'h1);
   assign os_req_rise = os_sleep_req && !os_req_prev_reg;

   always_comb begin
      unique case (st_reg)
         pbw_pkg::PBW_S0: wake_mask = 9'h000;
         pbw_pkg::PBW_S1, pbw_pkg::PBW_S3: wake_mask = pbw_pkg::WAKE_MASK_S1S3;
         pbw_pkg::PBW_S4: wake_mask = pbw_pkg::WAKE_MASK_S4S5;
         pbw_pkg::PBW_S5: wake_mask = en_sync_reg ? pbw_pkg::WAKE_MASK_S4S5
                                      : (pbw_pkg::WAKE_MASK_S4S5 & ~pbw_pkg::WAKE_LAN_PME);
         default: wake_mask = 9'h000;
      endcase
   end

   assign wake_hit = |(wk_sync_reg & wake_mask);

   always_comb begin
      st_next = st_reg;
      press_next = press_reg;
      long_done_next = long_done_reg;
      cold_next = 1'b0;
      ack_next = 1'b0;
      if (sw_clean) begin
         if (!long_done_reg) begin
            press_next = press_reg + 32'h1;
         end
      end else begin
         press_next = 32'h0;
         long_done_next = 1'b0;
      end
      if (long_hit) begin
         long_done_next = 1'b1;
      end
      unique case (st_reg)
         pbw_pkg::PBW_S0: begin
            if (long_hit) begin
               st_next = pbw_pkg::PBW_S5;
            end else if (short_rel) begin
               st_next = pbw_pkg::PBW_S1;
            end else if (os_req_rise) begin
               ack_next = 1'b1;
               unique case (os_sleep_state)
                  pbw_pkg::STATE_S3: st_next = pbw_pkg::PBW_S3;
                  pbw_pkg::STATE_S4: st_next = pbw_pkg::PBW_S4;
                  pbw_pkg::STATE_S5: st_next = pbw_pkg::PBW_S5;
                  default: st_next = pbw_pkg::PBW_S1;
               endcase
            end
         end
         pbw_pkg::PBW_S1, pbw_pkg::PBW_S3, pbw_pkg::PBW_S4: begin
            if (long_hit) begin
               st_next = pbw_pkg::PBW_S5;
            end else if (short_rel || wake_hit) begin
               st_next = pbw_pkg::PBW_S0;
            end
         end
         pbw_pkg::PBW_S5: begin
            if (short_rel || wake_hit) begin
               st_next = pbw_pkg::PBW_S0;
               cold_next = 1'b1;
            end
         end
         default: st_next = pbw_pkg::PBW_S5;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_reg <= pbw_pkg::PBW_S5;
         press_reg <= 32'h0;
         long_done_reg <= 1'b0;
         cold_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         press_reg <= press_next;
         long_done_reg <= long_done_next;
         cold_reg <= cold_next;
         ack_reg <= ack_next;
      end
   end

   // registered outputs
   logic [2:0] code_reg;
   logic sg_reg;
   logic pwr_reg;
   logic [2:0] code_next;
   logic sg_next;
   logic pwr_next;

   always_comb begin
      sg_next = (st_next == pbw_pkg::PBW_S1);
      pwr_next = (st_next == pbw_pkg::PBW_S0) || (st_next == pbw_pkg::PBW_S1);
      unique case (st_next)
         pbw_pkg::PBW_S0: code_next = pbw_pkg::STATE_S0;
         pbw_pkg::PBW_S1: code_next = pbw_pkg::STATE_S1;
         pbw_pkg::PBW_S3: code_next = pbw_pkg::STATE_S3;
         pbw_pkg::PBW_S4: code_next = pbw_pkg::STATE_S4;
         default: code_next = pbw_pkg::STATE_S5;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         code_reg <= pbw_pkg::STATE_S5;
         sg_reg <= 1'b0;
         pwr_reg <= 1'b0;
      end else begin
         code_reg <= code_next;
         sg_reg <= sg_next;
         pwr_reg <= pwr_next;
      end
   end

   assign pwr_state = code_reg;
   assign stop_grant = sg_reg;
   assign main_pwr_on = pwr_reg;
   assign cold_boot = cold_reg;
   assign sleep_req_ack = ack_reg;
endmodule : pbw_ctrl

// ===== tb/pbw_ctrl_assertions.sv
`timescale 1ns/100ps
module pbw_ctrl_chk (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic rtc_alarm,
   input wire logic [2:0] pwr_state,
   input wire logic stop_grant,
   input wire logic main_pwr_on,
   input wire logic cold_boot,
   input wire logic sleep_req_ack
);
   wire logic s0 = pwr_state == pbw_pkg::STATE_S0;
   wire logic s1 = pwr_state == pbw_pkg::STATE_S1;
   wire logic s3 = pwr_state == pbw_pkg::STATE_S3;
   wire logic s5 = pwr_state == pbw_pkg::STATE_S5;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   a_main_pwr_map: assert property (main_pwr_on == (s0 || s1))
      else $error("main power wrong");
   a_stop_grant_s1: assert property (stop_grant == s1)
      else $error("stop grant wrong");
   a_cold_boot_src: assert property (cold_boot |-> s0 && $past(s5))
      else $error("cold boot not from soft off");
   a_cold_boot_pulse: assert property (cold_boot |=> !cold_boot)
      else $error("cold boot too long");
   a_s5_exit_boot: assert property ($past(s5) && !s5 |-> s0 && cold_boot)
      else $error("soft off exit wrong");
   a_s1_no_restart: assert property ($past(s1) && !s1 |-> !cold_boot)
      else $error("restart on leaving S1");
   a_sleep_exit_dest: assert property ($past(!s0) && $changed(pwr_state) |-> s0 || s5)
      else $error("bad sleep exit");
   a_rtc_wake: assert property ((s3 || s5) && rtc_alarm |-> ##[1:6] s0)
      else $error("alarm did not wake");
   cover property (sleep_req_ack);
   cover property (cold_boot);
   cover property ($past(s0) && s5);
endmodule : pbw_ctrl_chk

// ===== tb/pbw_panel.sv
`timescale 1ns/100ps
module pbw_panel (
   input wire logic clk_sys,
   output logic pwr_sw_n
);
   initial begin
      pwr_sw_n = 1'b1;
   end
   task hold(input int n);
      @(negedge clk_sys);
      pwr_sw_n = 1'b0;
      repeat (n) @(negedge clk_sys);
   endtask : hold
   task rel();
      pwr_sw_n = 1'b1;
      repeat (3000) @(negedge clk_sys);
   endtask : rel
endmodule : pbw_panel

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic clk_sys;
   logic rstn;
   logic en;
   logic os_sleep_req;
   logic pwr_sw_n;
   logic stop_grant, main_pwr_on, cold_boot, sleep_req_ack;
   logic [2:0] os_sleep_state;
   logic [2:0] pwr_state;
   logic [2:0] t;
   logic [7:0] w;
   logic [31:0] r;
   logic [2:0] tgt [4] = '{pbw_pkg::STATE_S1, pbw_pkg::STATE_S3, pbw_pkg::STATE_S4,
      pbw_pkg::STATE_S5};
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int boots = 0;
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   pbw_panel u_pan (.clk_sys(clk_sys), .pwr_sw_n(pwr_sw_n));
   pbw_ctrl #(.LONG_PRESS(32'h00001388)) dut (.clk_sys(clk_sys), .rstn(rstn),
      .pwr_sw_n(pwr_sw_n), .rtc_alarm(w[0]), .lan_wake(w[1]), .power_mgmt_event_n(~w[2]),
      .riser_wake(w[3]), .riser_usb_wake(w[4]), .ring_a(w[5]), .usb_wake(w[6]),
      .ps2_wake(w[7]), .s5_lan_pme_en(en), .os_sleep_req(os_sleep_req),
      .os_sleep_state(os_sleep_state), .pwr_state(pwr_state), .stop_grant(stop_grant),
      .main_pwr_on(main_pwr_on), .cold_boot(cold_boot), .sleep_req_ack(sleep_req_ack));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [2:0] exp_st(input logic [2:0] g, input logic [7:0] v,
      input logic e);
      logic [7:0] m;
      m = (g == pbw_pkg::STATE_S1 || g == pbw_pkg::STATE_S3) ? 8'hFF : 8'h0F;
      if (g == pbw_pkg::STATE_S5 && !e)
         m = 8'h09;
      return (|(v & m)) ? pbw_pkg::STATE_S0 : g;
   endfunction : exp_st
   task chk(input string n, input logic [2:0] e, input logic [2:0] g);
      comparisons++;
      if (g !== e) begin
         $display("unexpected %s exp %0h got %0h", n, e, g);
         num_errors++;
      end
   endtask : chk
   task final_report();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task do_reset();
      rstn = 1'b0;
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      chk("reset state", pbw_pkg::STATE_S5, pwr_state);
   endtask : do_reset
   task out_chk(input logic [2:0] e);
      chk("stop grant", {2'b00, e == pbw_pkg::STATE_S1}, {2'b00, stop_grant});
      chk("main power", {2'b00, e == pbw_pkg::STATE_S0 || e == pbw_pkg::STATE_S1},
         {2'b00, main_pwr_on});
   endtask : out_chk
   task go(input logic [2:0] g);
      @(negedge clk_sys);
      os_sleep_state = g;
      os_sleep_req = 1'b1;
      for (int i = 0; i < 10 && sleep_req_ack !== 1'b1; i++) @(negedge clk_sys);
      os_sleep_req = 1'b0;
      chk("os ack", 3'h1, {2'b00, sleep_req_ack});
      chk("os state", g, pwr_state);
      out_chk(g);
      @(negedge clk_sys);
      chk("os ack end", 3'h0, {2'b00, sleep_req_ack});
   endtask : go
   task sp(input logic [2:0] e, input logic [2:0] b);
      int n;
      n = boots;
      u_pan.hold(3000);
      u_pan.rel();
      chk("press state", e, pwr_state);
      chk("cold boot", b, 3'(boots - n));
      out_chk(e);
   endtask : sp
   always @(negedge clk_sys) begin
      if (cold_boot === 1'b1) begin
         boots++;
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 100000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      w = 8'h00;
      en = 1'b0;
      os_sleep_req = 1'b0;
      os_sleep_state = 3'h0;
      r = 32'h0000EC81;
      do_reset();
      w = 8'hF6;
      repeat (10) @(negedge clk_sys);
      chk("soft off state", pbw_pkg::STATE_S5, pwr_state);
      en = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk("enabled wake", pbw_pkg::STATE_S0, pwr_state);
      w = 8'h00;
      repeat (4) @(negedge clk_sys);
      for (int k = 0; k < 40; k++) begin
         r = lfsr(r);
         en = r[0];
         t = tgt[r[2:1]];
         go(t);
         w = r[15:8];
         repeat (10) @(negedge clk_sys);
         chk("wake state", exp_st(t, w, en), pwr_state);
         w = 8'h01;
         repeat (10) @(negedge clk_sys);
         w = 8'h00;
         repeat (4) @(negedge clk_sys);
      end
      $display("test wake done");
      do_reset();
      sp(pbw_pkg::STATE_S0, 3'h1);
      sp(pbw_pkg::STATE_S1, 3'h0);
      sp(pbw_pkg::STATE_S0, 3'h0);
      u_pan.hold(7400);
      chk("hold state", pbw_pkg::STATE_S0, pwr_state);
      u_pan.hold(200);
      chk("hold state", pbw_pkg::STATE_S5, pwr_state);
      out_chk(pbw_pkg::STATE_S5);
      u_pan.rel();
      chk("release state", pbw_pkg::STATE_S5, pwr_state);
      sp(pbw_pkg::STATE_S0, 3'h1);
      go(pbw_pkg::STATE_S3);
      u_pan.hold(7700);
      u_pan.rel();
      chk("sleep hold state", pbw_pkg::STATE_S5, pwr_state);
      $display("test switch done");
      final_report();
   end
endmodule : tb
bind pbw_ctrl pbw_ctrl_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .rtc_alarm(rtc_alarm),
   .pwr_state(pwr_state), .stop_grant(stop_grant), .main_pwr_on(main_pwr_on),
   .cold_boot(cold_boot), .sleep_req_ack(sleep_req_ack));
